// ==== verilog/voice_serial_command_ctrl.sv ====
// Serial command front end and playback state controller
// Operation
// - Load-next buffers address, raises flag, plays gaplessly, flag drops on start
// - Play loads address, stops current group, starts new one
// - 16-bit words MSB first; opcode bits 15:10, address bits 9:0
// - Opcodes: load, play, both power-ups, both power-downs
// - Opcodes: volume set, decrement, increment, pause, resume, rewind
// - Volume set takes index from bits 3:0; 0 loudest
// - Volume decrement/increment steps index by one
// - Direct power-up sets output to centre at once
// - Ramped power-up ramps bottom to centre over 160 ms
// - Direct power-down drops to bottom; only after direct power-up
// - Ramped power-down ramps to bottom; only after ramped power-up
// - Pause holds speaker outputs low, freezes DAC; resume continues
// - Rewind restarts current group from its start
// - Reset and configuration float the trigger pin and reject commands
// - Idle: activating command to play, timeout to sleep
// - Play goes to wait when empty; deactivating command sleeps
// - Selection in sleep wakes; one command buffered; then play or idle
// - Three-wire: chip select frames word, data sampled on rising clock
// - Two-wire: start/stop frame word, bits latched on rising clock
// - Two-wire: trigger pin reports busy during playback or ramp
// - Load indicator rises once load-next address accepted
`timescale 1ns/1ns
`include "vsc_params.svh"
module voice_serial_command_ctrl #(
	parameter int unsigned CFG_CYCLES  = `CFG_MS * 1000 * `CLK_MHZ,
	parameter int unsigned WAKE_CYCLES = `WAKE_MS * 1000 * `CLK_MHZ,
	parameter int unsigned IDLE_CYCLES = `IDLE_MS * 1000 * `CLK_MHZ,
	parameter int unsigned RAMP_CYCLES = `RAMP_MS * 1000 * `CLK_MHZ
)(
	input  wire logic          ref_clk_i,
	input  wire logic          rst_i,
	input  wire logic          serial_clock_pin_i,
	input  wire logic          serial_data_pin_i,
	input  wire logic          chip_select_n_i,
	input  wire logic          two_wire_mode_i,
	input  wire logic          fb_load_mode_i,
	input  wire logic          group_done_i,
	input  wire logic          pwm_a_i,
	input  wire logic          pwm_b_i,
	input  wire logic [15:0]   dac_sample_i,
	output logic               trigger_select_pin_o,
	output logic               trigger_select_oe_o,
	output logic               pwm_speaker_out_a_o,
	output logic               pwm_speaker_out_b_o,
	output logic [15:0]        dac_current_out_o,
	output logic [9:0]         play_group_o,
	output logic               play_start_o,
	output logic               play_pause_o,
	output logic [3:0]         volume_o,
	output logic               power_on_o,
	output vsc_pkg::state_t    state_o
);
	localparam int unsigned RAMP_Q = RAMP_CYCLES / `RAMP_LEVELS;
	localparam int unsigned RAMP_STEP = (RAMP_Q > 0) ? RAMP_Q : 1;

	// ------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------
	// Opcode decoding
	function automatic vsc_pkg::cmd_t decode_cmd(input logic [5:0] op);
		case (op)
		`OP_LOAD:   decode_cmd = vsc_pkg::C_LOAD;
		`OP_PLAY:   decode_cmd = vsc_pkg::C_PLAY;
		`OP_PU1:    decode_cmd = vsc_pkg::C_PU1;
		`OP_PU2:    decode_cmd = vsc_pkg::C_PU2;
		`OP_PD1:    decode_cmd = vsc_pkg::C_PD1;
		`OP_PD2:    decode_cmd = vsc_pkg::C_PD2;
		`OP_VSET:   decode_cmd = vsc_pkg::C_VSET;
		`OP_VDEC:   decode_cmd = vsc_pkg::C_VDEC;
		`OP_VINC:   decode_cmd = vsc_pkg::C_VINC;
		`OP_PAUSE:  decode_cmd = vsc_pkg::C_PAUSE;
		`OP_RESUME: decode_cmd = vsc_pkg::C_RESUME;
		`OP_REWIND: decode_cmd = vsc_pkg::C_REWIND;
		default:    decode_cmd = vsc_pkg::C_NONE;
		endcase
	endfunction : decode_cmd

	function automatic logic is_act(input vsc_pkg::cmd_t c);
		is_act = (c == vsc_pkg::C_LOAD) || (c == vsc_pkg::C_PLAY) ||
			(c == vsc_pkg::C_PU1) || (c == vsc_pkg::C_PU2);
	endfunction : is_act

	// ------------------------------------------------------------
	// Link domain
	// ------------------------------------------------------------
	logic                 link_rst;
	logic                 frame_idle_reg;
	logic                 tw_mode;
	logic [3:0]           bit_cnt_reg;
	logic [14:0]          shift_reg;
	vsc_pkg::cmd_word_t   word_hold_reg;
	logic                 word_tgl_reg;

	// Frame signal clears the bit count; the link clock may stop between words
	assign link_rst = rst_i | (tw_mode ? frame_idle_reg : chip_select_n_i);

	always_ff @(posedge serial_clock_pin_i or posedge link_rst)
	begin
		if (link_rst)
		begin
			bit_cnt_reg <= 4'h0;
			shift_reg   <= 15'h0000;
		end
		else
		begin
			shift_reg   <= {shift_reg[13:0], serial_data_pin_i};
			bit_cnt_reg <= bit_cnt_reg + 4'h1;
		end
	end

	always_ff @(posedge serial_clock_pin_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			word_hold_reg <= 16'h0000;
			word_tgl_reg  <= 1'h0;
		end
		else if (bit_cnt_reg == 4'hf)
		begin
			word_hold_reg <= {shift_reg, serial_data_pin_i};
			word_tgl_reg  <= ~word_tgl_reg;
		end
	end

	// Checked at the next link clock edge (the next word's first, or the stop pulse in two-wire), so frame end must not abort it
	a_bit_order: assert property (@(posedge serial_clock_pin_i)
		disable iff (rst_i)
		bit_cnt_reg == 4'hf |=> word_hold_reg[0] == $past(serial_data_pin_i))
		else $error("last bit not latched on rising clock");

	// ------------------------------------------------------------
	// Synchronisers and framing
	// ------------------------------------------------------------
	logic [4:0] sync1_reg;
	logic [4:0] sync2_reg;
	logic [4:0] sync3_reg;
	logic       start_evt;
	logic       stop_evt;
	logic       select_evt;
	logic       new_word;

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			sync1_reg <= `SYNC_RST;
			sync2_reg <= `SYNC_RST;
			sync3_reg <= `SYNC_RST;
		end
		else
		begin
			sync1_reg <= {word_tgl_reg, two_wire_mode_i, chip_select_n_i,
				serial_clock_pin_i, serial_data_pin_i};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	assign tw_mode = sync2_reg[3];
	// Start and stop while clock high
	assign start_evt = tw_mode & sync2_reg[1] & sync3_reg[1] &
		sync3_reg[0] & ~sync2_reg[0];
	assign stop_evt = tw_mode & sync2_reg[1] & sync3_reg[1] &
		~sync3_reg[0] & sync2_reg[0];
	assign select_evt = start_evt | (~tw_mode & sync3_reg[2] & ~sync2_reg[2]);
	// Word is stable long before its toggle is seen here
	assign new_word = sync2_reg[4] ^ sync3_reg[4];

	// Frame held idle between stop and start
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			frame_idle_reg <= 1'h1;
		else if (start_evt)
			frame_idle_reg <= 1'h0;
		else if (stop_evt)
			frame_idle_reg <= 1'h1;
	end

	// ------------------------------------------------------------
	// Command execution
	// ------------------------------------------------------------
	vsc_pkg::state_t    state_reg;
	vsc_pkg::state_t    state_next;
	logic [31:0]        tmr_reg;
	logic               buf_valid_reg;
	vsc_pkg::cmd_word_t buf_word_reg;
	logic               cmd_open;
	logic               wake_exec;
	vsc_pkg::cmd_word_t exec_word;
	logic               exec_go;
	vsc_pkg::cmd_t      exec_cmd;
	logic               power_reg;
	logic               ramp_mode_reg;
	logic               ramp_up_reg;
	logic               ramp_dn_reg;
	logic [31:0]        step_cnt_reg;
	logic [15:0]        dac_reg;
	logic               playing_reg;
	logic               paused_reg;
	logic [9:0]         cur_group_reg;
	logic               start_reg;
	logic               pend_valid_reg;
	logic [9:0]         pend_addr_reg;
	logic [3:0]         vol_reg;
	logic               tick;
	logic               do_pd1;
	logic               do_pd2;
	logic               go_sleep;
	logic               busy;
	logic               consume;

	// Commands only in idle, play and wait
	assign cmd_open = (state_reg == vsc_pkg::ST_IDLE) ||
		(state_reg == vsc_pkg::ST_PLAY) || (state_reg == vsc_pkg::ST_WAIT);
	assign wake_exec = (state_reg == vsc_pkg::ST_WAKE) &&
		(tmr_reg >= WAKE_CYCLES - 1);
	assign exec_word = wake_exec ? buf_word_reg : word_hold_reg;
	assign exec_go = (new_word & cmd_open) | (wake_exec & buf_valid_reg);
	assign exec_cmd = exec_go ? decode_cmd(exec_word.opcode) : vsc_pkg::C_NONE;

	// Direct power-down only after direct power-up
	assign do_pd1 = (exec_cmd == vsc_pkg::C_PD1) & power_reg & ~ramp_mode_reg;
	// Ramped power-down only after ramped power-up
	assign do_pd2 = (exec_cmd == vsc_pkg::C_PD2) & power_reg & ramp_mode_reg &
		~ramp_dn_reg;
	assign tick = step_cnt_reg == RAMP_STEP - 1;
	assign go_sleep = do_pd1 | (ramp_dn_reg & tick & (dac_reg == `DAC_BOTTOM));
	assign busy = playing_reg | ramp_up_reg | ramp_dn_reg | pend_valid_reg;
	assign consume = group_done_i & playing_reg & pend_valid_reg &
		(exec_cmd != vsc_pkg::C_PLAY) & (exec_cmd != vsc_pkg::C_REWIND);

	// One command held across sleep and wakeup
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			buf_valid_reg <= 1'h0;
			buf_word_reg  <= 16'h0000;
		end
		else if (wake_exec)
			buf_valid_reg <= 1'h0;
		else if (new_word && !buf_valid_reg &&
			(state_reg == vsc_pkg::ST_SLEEP || state_reg == vsc_pkg::ST_WAKE))
		begin
			buf_valid_reg <= 1'h1;
			buf_word_reg  <= word_hold_reg;
		end
	end

	// ------------------------------------------------------------
	// State machine
	// ------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
		vsc_pkg::ST_RESET:
			if (tmr_reg >= `POR_CYC - 1)
				state_next = vsc_pkg::ST_CONFIG;
		vsc_pkg::ST_CONFIG:
			if (tmr_reg >= CFG_CYCLES - 1)
				state_next = vsc_pkg::ST_IDLE;
		vsc_pkg::ST_IDLE:
			if (exec_go && is_act(exec_cmd))
				state_next = vsc_pkg::ST_PLAY;
			else if (tmr_reg >= IDLE_CYCLES - 1)
				state_next = vsc_pkg::ST_SLEEP;
		// Drain to wait, deactivate to sleep
		vsc_pkg::ST_PLAY:
			if (go_sleep)
				state_next = vsc_pkg::ST_SLEEP;
			else if (!busy && !is_act(exec_cmd))
				state_next = vsc_pkg::ST_WAIT;
		vsc_pkg::ST_WAIT:
			if (go_sleep)
				state_next = vsc_pkg::ST_SLEEP;
			else if (is_act(exec_cmd) || busy)
				state_next = vsc_pkg::ST_PLAY;
		vsc_pkg::ST_SLEEP:
			if (select_evt)
				state_next = vsc_pkg::ST_WAKE;
		vsc_pkg::ST_WAKE:
			if (wake_exec)
				state_next = (buf_valid_reg && is_act(exec_cmd)) ?
					vsc_pkg::ST_PLAY : vsc_pkg::ST_IDLE;
		default:
			state_next = vsc_pkg::ST_RESET;
		endcase
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			state_reg <= vsc_pkg::ST_RESET;
			tmr_reg   <= 32'h0;
		end
		else
		begin
			state_reg <= state_next;
			tmr_reg   <= (state_next != state_reg) ? 32'h0 : tmr_reg + 32'h1;
		end
	end

	// ------------------------------------------------------------
	// Power and ramps
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i || !(ramp_up_reg || ramp_dn_reg) || tick)
			step_cnt_reg <= 32'h0;
		else
			step_cnt_reg <= step_cnt_reg + 32'h1;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			power_reg     <= 1'h0;
			ramp_mode_reg <= 1'h0;
			ramp_up_reg   <= 1'h0;
			ramp_dn_reg   <= 1'h0;
			dac_reg       <= `DAC_BOTTOM;
		end
		else if (exec_cmd == vsc_pkg::C_PU1)
		begin
			power_reg     <= 1'h1;
			ramp_mode_reg <= 1'h0;
			ramp_up_reg   <= 1'h0;
			ramp_dn_reg   <= 1'h0;
			dac_reg       <= `DAC_CENTRE;
		end
		else if (exec_cmd == vsc_pkg::C_PU2)
		begin
			power_reg     <= 1'h1;
			ramp_mode_reg <= 1'h1;
			ramp_up_reg   <= 1'h1;
			ramp_dn_reg   <= 1'h0;
			dac_reg       <= `DAC_BOTTOM;
		end
		else if (do_pd1)
		begin
			power_reg <= 1'h0;
			dac_reg   <= `DAC_BOTTOM;
		end
		else if (do_pd2)
		begin
			ramp_up_reg <= 1'h0;
			ramp_dn_reg <= 1'h1;
		end
		else if (ramp_up_reg && tick)
		begin
			dac_reg <= dac_reg + 16'h1;
			if (dac_reg == `DAC_CENTRE - 16'h1)
				ramp_up_reg <= 1'h0;
		end
		else if (ramp_dn_reg && tick)
		begin
			if (dac_reg == `DAC_BOTTOM)
			begin
				ramp_dn_reg <= 1'h0;
				power_reg   <= 1'h0;
			end
			else
				dac_reg <= dac_reg - 16'h1;
		end
		else if (playing_reg && !paused_reg && power_reg &&
			!ramp_up_reg && !ramp_dn_reg)
			dac_reg <= dac_sample_i;
	end

	// ------------------------------------------------------------
	// Playback control
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			playing_reg   <= 1'h0;
			paused_reg    <= 1'h0;
			cur_group_reg <= 10'h000;
			start_reg     <= 1'h0;
		end
		else
		begin
			start_reg <= 1'h0;
			// Next group follows with no gap
			if (group_done_i && playing_reg)
			begin
				if (pend_valid_reg)
				begin
					cur_group_reg <= pend_addr_reg;
					start_reg     <= 1'h1;
				end
				else
					playing_reg <= 1'h0;
			end
			case (exec_cmd)
			vsc_pkg::C_PLAY:
			begin
				cur_group_reg <= exec_word.arg;
				start_reg     <= 1'h1;
				playing_reg   <= 1'h1;
				paused_reg    <= 1'h0;
			end
			vsc_pkg::C_REWIND:
			begin
				start_reg   <= 1'h1;
				playing_reg <= 1'h1;
				paused_reg  <= 1'h0;
			end
			vsc_pkg::C_PAUSE:
				paused_reg <= playing_reg;
			vsc_pkg::C_RESUME:
				paused_reg <= 1'h0;
			default:
				paused_reg <= paused_reg;
			endcase
		end
	end

	// Load sets the flag; set wins over release
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			pend_valid_reg <= 1'h0;
			pend_addr_reg  <= 10'h000;
		end
		else if (exec_cmd == vsc_pkg::C_LOAD)
		begin
			pend_valid_reg <= 1'h1;
			pend_addr_reg  <= exec_word.arg;
		end
		else if (consume)
			pend_valid_reg <= 1'h0;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			vol_reg <= `VOL_RST;
		else if (exec_cmd == vsc_pkg::C_VSET)
			vol_reg <= exec_word.arg[`VOL_HI:0];
		else if (exec_cmd == vsc_pkg::C_VDEC && vol_reg != `VOL_RST)
			vol_reg <= vol_reg - 4'h1;
		else if (exec_cmd == vsc_pkg::C_VINC && vol_reg != `VOL_MAX)
			vol_reg <= vol_reg + 4'h1;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			trigger_select_pin_o <= 1'h0;
			trigger_select_oe_o  <= 1'h0;
			pwm_speaker_out_a_o  <= 1'h0;
			pwm_speaker_out_b_o  <= 1'h0;
		end
		else
		begin
			// Busy or load indicator in two-wire mode
			trigger_select_pin_o <= fb_load_mode_i ? pend_valid_reg : busy;
			trigger_select_oe_o  <= tw_mode &&
				state_reg != vsc_pkg::ST_RESET &&
				state_reg != vsc_pkg::ST_CONFIG;
			pwm_speaker_out_a_o  <= pwm_a_i & power_reg & ~paused_reg;
			pwm_speaker_out_b_o  <= pwm_b_i & power_reg & ~paused_reg;
		end
	end

	assign dac_current_out_o = dac_reg;
	assign play_group_o      = cur_group_reg;
	assign play_start_o      = start_reg;
	assign play_pause_o      = paused_reg;
	assign volume_o          = vol_reg;
	assign power_on_o        = power_reg;
	assign state_o           = state_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	sequence s_idle_act;
		state_reg == vsc_pkg::ST_IDLE && exec_go && is_act(exec_cmd);
	endsequence

	sequence s_play_cmd;
		exec_cmd == vsc_pkg::C_PLAY;
	endsequence

	a_load_flag: assert property (
		exec_cmd == vsc_pkg::C_LOAD |=> pend_valid_reg ##1
		(pend_valid_reg || play_start_o))
		else $error("load did not raise pending flag");
	a_play_start: assert property (
		s_play_cmd |=> play_start_o && play_group_o == $past(exec_word.arg))
		else $error("play did not start addressed group");
	a_vol_set: assert property (
		exec_cmd == vsc_pkg::C_VSET |=> volume_o == $past(exec_word.arg[3:0]))
		else $error("volume set wrong");
	a_vol_step: assert property (
		exec_cmd == vsc_pkg::C_VINC && vol_reg != `VOL_MAX
		|=> volume_o == $past(vol_reg) + 4'h1)
		else $error("volume increment wrong");
	a_pu_centre: assert property (
		exec_cmd == vsc_pkg::C_PU1 |=> dac_current_out_o == `DAC_CENTRE)
		else $error("direct power-up not at centre");
	a_pd_bottom: assert property (
		do_pd1 |=> dac_current_out_o == `DAC_BOTTOM && !power_on_o
		##1 state_o == vsc_pkg::ST_SLEEP)
		else $error("direct power-down wrong");
	a_pause_low: assert property (
		paused_reg |=> !pwm_speaker_out_a_o && !pwm_speaker_out_b_o)
		else $error("speaker outputs not low in pause");
	a_boot_reject: assert property (
		new_word && !cmd_open && state_reg != vsc_pkg::ST_SLEEP &&
		state_reg != vsc_pkg::ST_WAKE |=> $stable(vol_reg) &&
		$stable(pend_valid_reg) && $stable(power_reg))
		else $error("command accepted while inhibited");
	a_idle_play: assert property (
		s_idle_act |=> state_o == vsc_pkg::ST_PLAY)
		else $error("activating command did not reach play");
	a_wait_entry: assert property (
		state_reg == vsc_pkg::ST_PLAY && !busy && !go_sleep &&
		exec_cmd == vsc_pkg::C_NONE |=> state_o == vsc_pkg::ST_WAIT)
		else $error("play did not drain to wait");
	a_sleep_wake: assert property (
		state_reg == vsc_pkg::ST_SLEEP && select_evt
		|=> state_o == vsc_pkg::ST_WAKE)
		else $error("selection did not wake");
	a_busy_pin: assert property (
		!fb_load_mode_i && tw_mode |=> trigger_select_pin_o == $past(busy))
		else $error("busy output does not follow state");
	a_rewind: assert property (
		exec_cmd == vsc_pkg::C_REWIND |=> play_start_o &&
		play_group_o == $past(cur_group_reg))
		else $error("rewind did not restart group");
endmodule : voice_serial_command_ctrl

// ==== inc/vsc_params.svh ====
// Constants for the serial command controller
`ifndef VSC_PARAMS_SVH
`define VSC_PARAMS_SVH
`define OP_HI 15
`define OP_LO 10
`define ARG_HI 9
`define VOL_HI 3
`define OP_LOAD 6'h25
`define OP_PLAY 6'h26
`define OP_PU1 6'h29
`define OP_PU2 6'h2a
`define OP_PD1 6'h2d
`define OP_PD2 6'h2e
`define OP_VSET 6'h11
`define OP_VDEC 6'h12
`define OP_VINC 6'h15
`define OP_PAUSE 6'h19
`define OP_RESUME 6'h1a
`define OP_REWIND 6'h1d
`define VOL_RST 4'h0
`define VOL_MAX 4'hf
`define DAC_CENTRE 16'h8000
`define DAC_BOTTOM 16'h0000
`define SYNC_RST 5'h04
`define CLK_MHZ 250
`define POR_US 5
`define POR_CYC (`POR_US * `CLK_MHZ)
`define CFG_MS 2
`define WAKE_MS 2
`define IDLE_MS 10
`define RAMP_MS 160
`define RAMP_LEVELS 32768
`endif

// ==== inc/vsc_pkg.sv ====
// Types for the serial command controller
package vsc_pkg;
	typedef enum logic [2:0] {
		ST_RESET  = 3'b000,
		ST_CONFIG = 3'b001,
		ST_IDLE   = 3'b010,
		ST_PLAY   = 3'b011,
		ST_WAIT   = 3'b100,
		ST_SLEEP  = 3'b101,
		ST_WAKE   = 3'b110
	} state_t;
	typedef enum logic [3:0] {
		C_NONE = 4'h0, C_LOAD = 4'h1, C_PLAY = 4'h2, C_PU1 = 4'h3,
		C_PU2 = 4'h4, C_PD1 = 4'h5, C_PD2 = 4'h6, C_VSET = 4'h7,
		C_VDEC = 4'h8, C_VINC = 4'h9, C_PAUSE = 4'ha, C_RESUME = 4'hb,
		C_REWIND = 4'hc
	} cmd_t;
	typedef struct packed {
		logic [5:0] opcode;
		logic [9:0] arg;
	} cmd_word_t;
endpackage : vsc_pkg

// ==== bench/host_link_model.sv ====
// Host model that drives three-wire and two-wire command words
`timescale 1ns/1ns
module host_link_model (
	output logic serial_clock_o,
	output logic serial_data_o,
	output logic chip_select_n_o
);
	initial
	begin
		serial_clock_o = 1'b0;
		serial_data_o = 1'b0;
		chip_select_n_o = 1'b1;
	end
	task automatic send_word(input logic [15:0] word);
		#7 chip_select_n_o = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			serial_data_o = word[i];
			#16 serial_clock_o = 1'b1;
			#16 serial_clock_o = 1'b0;
		end
		#16 chip_select_n_o = 1'b1;
		// Released line falls to its pull-down
		serial_data_o = 1'b0;
	endtask : send_word
	// Stop condition, data rises with clock high
	task automatic send_stop();
		serial_data_o = 1'b0;
		#16 serial_clock_o = 1'b1;
		#16 serial_data_o = 1'b1;
		#16 serial_clock_o = 1'b0;
		// Data drops only with the clock low, so no false start
		#16 serial_data_o = 1'b0;
	endtask : send_stop
	task automatic send_word_tw(input logic [15:0] word);
		#7 serial_data_o = 1'b1;
		#16 serial_clock_o = 1'b1;
		#16 serial_data_o = 1'b0;
		#16 serial_clock_o = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			serial_data_o = word[i];
			#16 serial_clock_o = 1'b1;
			#16 serial_clock_o = 1'b0;
		end
		send_stop();
	endtask : send_word_tw
endmodule : host_link_model

// ==== bench/voice_serial_command_ctrl_bench.sv ====
// Self-checking bench for the serial command controller
`timescale 1ns/1ns
`include "vsc_params.svh"
module voice_serial_command_ctrl_bench;
	logic            clk, rst, sclk, sdata, csn, done, pin, oe;
	logic            tw, fbl, pa, pb;
	logic            out_a, out_b, start, pause, pwr;
	logic [15:0]     sample, dac, d;
	logic [9:0]      grp, a1, a2;
	logic [3:0]      vol;
	vsc_pkg::state_t st;
	int              errors, checked, starts, s0, cycles, seed, k, vm;
	host_link_model host_link_model_inst (
		.serial_clock_o  (sclk),
		.serial_data_o   (sdata),
		.chip_select_n_o (csn)
	);
	voice_serial_command_ctrl #(.CFG_CYCLES(50), .WAKE_CYCLES(200),
		.IDLE_CYCLES(200), .RAMP_CYCLES(32768))
	voice_serial_command_ctrl_inst (
		.ref_clk_i(clk), .rst_i(rst), .serial_clock_pin_i(sclk),
		.serial_data_pin_i(sdata), .chip_select_n_i(csn),
		.two_wire_mode_i(tw), .fb_load_mode_i(fbl),
		.group_done_i(done), .pwm_a_i(pa), .pwm_b_i(pb),
		.dac_sample_i(sample), .trigger_select_pin_o(pin),
		.trigger_select_oe_o(oe), .pwm_speaker_out_a_o(out_a),
		.pwm_speaker_out_b_o(out_b), .dac_current_out_o(dac),
		.play_group_o(grp), .play_start_o(start), .play_pause_o(pause),
		.volume_o(vol), .power_on_o(pwr), .state_o(st)
	);
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (start === 1'b1)
			starts++;
		// Two ramps of 32768 cycles each dominate the run
		if (cycles == 80000)
		begin
			errors++;
			print_verdict();
		end
	end
	always @(negedge clk)
		sample <= $random(seed);
	task automatic check(input string n, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : check
	task automatic send(input logic [5:0] op, input logic [9:0] arg);
		if (tw)
			host_link_model_inst.send_word_tw({op, arg});
		else
			host_link_model_inst.send_word({op, arg});
		repeat (8) @(negedge clk);
	endtask : send
	task automatic finish_group();
		done = 1'b1;
		@(negedge clk);
		done = 1'b0;
		repeat (3) @(negedge clk);
	endtask : finish_group
	task automatic print_verdict();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict
	initial
	begin
		seed = 32'h05b2;
		{errors, checked, starts, cycles, vm} = '0;
		{done, tw} = 2'b00;
		{fbl, pa, pb} = 3'b111;
		rst = 1'b1;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		check("state", vsc_pkg::ST_RESET, st);
		send(`OP_PLAY, 10'h155);
		check("group", 16'h0, grp);
		for (int i = 0; i < 2000 && st !== vsc_pkg::ST_IDLE; i++)
			@(negedge clk);
		check("state", vsc_pkg::ST_IDLE, st);
		send(`OP_PU1, 10'h0);
		check("power", 16'h1, pwr);
		check("dac", `DAC_CENTRE, dac);
		// Scaled stand-in for the settle time after power-up
		repeat (100) @(negedge clk);
		for (int i = 0; i < 10; i++)
		begin
			k = $random(seed) & 3;
			a1 = $random(seed);
			case (k)
				0: send(`OP_VSET, {6'h0, a1[3:0]});
				1: send(`OP_VINC, a1);
				2: send(`OP_VDEC, a1);
				default: send(6'h3f, a1);
			endcase
			vm = (k == 0) ? a1[3:0] : (k == 1 && vm < 15) ? vm + 1 :
				(k == 2 && vm > 0) ? vm - 1 : vm;
			check("volume", vm[3:0], vol);
		end
		a1 = $random(seed);
		a2 = ~a1;
		s0 = starts;
		send(`OP_PLAY, a1);
		check("group", a1, grp);
		check("starts", 16'(s0 + 1), 16'(starts));
		check("state", vsc_pkg::ST_PLAY, st);
		send(`OP_LOAD, a2);
		check("load flag", 16'h1, pin);
		check("group", a1, grp);
		finish_group();
		check("group", a2, grp);
		check("load flag", 16'h0, pin);
		check("starts", 16'(s0 + 2), 16'(starts));
		send(`OP_PAUSE, 10'h0);
		check("pwm", 16'h0, {out_a, out_b});
		d = dac;
		repeat (20) @(negedge clk);
		check("dac", d, dac);
		send(`OP_RESUME, 10'h0);
		check("pwm", {14'h0, pa, pb}, {out_a, out_b});
		check("paused", 16'h0, pause);
		s0 = starts;
		send(`OP_REWIND, 10'h0);
		check("starts", 16'(s0 + 1), 16'(starts));
		check("group", a2, grp);
		finish_group();
		check("state", vsc_pkg::ST_WAIT, st);
		send(`OP_PD1, 10'h0);
		check("power", 16'h0, pwr);
		check("dac", `DAC_BOTTOM, dac);
		check("state", vsc_pkg::ST_SLEEP, st);
		send(`OP_PLAY, a1);
		check("state", vsc_pkg::ST_WAKE, st);
		repeat (220) @(negedge clk);
		check("state", vsc_pkg::ST_PLAY, st);
		check("group", a1, grp);
		// Two-wire link with busy feedback on the trigger pin
		tw = 1'b1;
		fbl = 1'b0;
		repeat (8) @(negedge clk);
		host_link_model_inst.send_stop();
		repeat (8) @(negedge clk);
		check("oe", 16'h1, oe);
		check("busy", 16'h1, pin);
		a1 = $random(seed);
		vm = a1[3:0];
		send(`OP_VSET, {6'h0, a1[3:0]});
		check("volume", vm[3:0], vol);
		finish_group();
		check("busy", 16'h0, pin);
		check("state", vsc_pkg::ST_WAIT, st);
		send(`OP_PU2, 10'h0);
		check("busy", 16'h1, pin);
		check("state", vsc_pkg::ST_PLAY, st);
		repeat (32800) @(negedge clk);
		check("dac", `DAC_CENTRE, dac);
		check("state", vsc_pkg::ST_WAIT, st);
		send(`OP_PD2, 10'h0);
		check("busy", 16'h1, pin);
		repeat (32800) @(negedge clk);
		check("dac", `DAC_BOTTOM, dac);
		check("power", 16'h0, pwr);
		check("state", vsc_pkg::ST_SLEEP, st);
		print_verdict();
	end
endmodule : voice_serial_command_ctrl_bench
